// File: core/wsi_top.sv
/*
  wsi_top: wake output, power event request and bus isolation logic with
  an AXI4-Lite register slave and a level interrupt.
  assumes bus_isolate_n and link events are synchronous to clk; aux_power_ok
  comes from an analog detector and is synchronised here.
*/
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
// Functional notes
// [R1] power event request is open-drain, active low
// [R2] isolate floats bus outputs, ignores bus inputs
// [R3] wake output has four styles, default high
// [R4] gate clear: wake and request assert together
// [R5] gate set: wake needs request and isolate
// [R6] cardbus mode: status change active high
// [R7] cardbus mode ignores level, pattern, gate
// [R8] aux power generates internal reset itself
// [R9] aux only: stay armed for wake events
// [R10] aux detect sets pm capability bits
// [R11] host runs wake sequence on wake output
// [R12] pulse styles give one fixed-length pulse
`timescale 1ns/1ps
module wsi_top
  import wsi_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // power and wake sources
  input  wire logic        aux_power_ok,
  input  wire logic        main_power_ok,
  input  wire logic        wake_packet_seen,
  input  wire logic        link_change_seen,
  // isolation and bus side
  input  wire logic        bus_isolate_n,
  input  wire logic        bus_rst_n,
  output logic             bus_out_enable_n,
  output logic             bus_in_accept,
  // power event request pin (open drain)
  output logic             power_event_request_n_out,
  output logic             power_event_request_n_oe,
  // board wake / status change pin
  output logic             board_wake_out,
  // interrupt
  output logic             irq
);
  // auxiliary power reset
  logic                    aux_sync;
  logic                    aux_prev;
  logic [CNT_W-1:0]        aux_rst_cnt;
  logic                    int_rst;
  // registers
  logic [CTRL_WIDTH-1:0]   ctrl;
  logic [IRQ_WIDTH-1:0]    int_stat;
  logic [IRQ_WIDTH-1:0]    int_mask;
  logic                    pme_pending;
  logic [15:0]             pm_cap;
  // axi state
  logic                    aw_held;
  logic                    w_held;
  logic [7:0]              aw_addr;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;

  wsi_sync u_aux_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (aux_power_ok),
    .dout    (aux_sync)
  );

  // internal reset stretched after aux power rises, no bus reset needed
  wire aux_rise = aux_sync && !aux_prev;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aux_prev    <= 1'b0;
      aux_rst_cnt <= CNT_W'(AUX_RST_CYCLES);
      int_rst     <= 1'b1;
    end else begin
      aux_prev <= aux_sync;
      if (aux_rise) begin
        aux_rst_cnt <= CNT_W'(AUX_RST_CYCLES); // [R8]
        int_rst     <= 1'b1;
      end else if (aux_rst_cnt != '0) begin
        aux_rst_cnt <= aux_rst_cnt - CNT_W'(1);
        int_rst     <= 1'b1;
      end else begin
        int_rst <= 1'b0;
      end
    end
  end

  // isolation: bus reset and bus inputs are ignored while isolated
  wire isolated     = !bus_isolate_n;
  wire bus_rst_used = !bus_rst_n && !isolated; // [R2]
  wire soft_rst     = int_rst || bus_rst_used;

  // wake sources are armed whenever aux power holds, main power or not
  wire armed     = aux_sync || main_power_ok;
  wire ev_packet = armed && wake_packet_seen; // [R9]
  wire ev_link   = armed && link_change_seen; // [R9]

  // axi write decode
  wire wr_fire   = aw_held && w_held && !s_axi_bvalid;
  wire wr_ctrl   = wr_fire && (aw_addr == OFF_CTRL) && w_strb[0];
  wire wr_mask   = wr_fire && (aw_addr == OFF_INT_MASK) && w_strb[0];
  wire wr_event  = wr_fire && (aw_addr == OFF_EVENT) && w_strb[0];
  wire wr_known  = (aw_addr == OFF_CTRL) || (aw_addr == OFF_INT_MASK)
                || (aw_addr == OFF_EVENT) || (aw_addr == OFF_STATUS)
                || (aw_addr == OFF_INT_STAT) || (aw_addr == OFF_PM_CAP);
  wire ev_force  = wr_event && w_data[EV_FORCE];
  wire ev_clear  = wr_event && w_data[EV_CLEAR];

  // axi read decode
  wire rd_fire   = s_axi_arvalid && s_axi_arready;
  wire rd_known  = (s_axi_araddr == OFF_CTRL) || (s_axi_araddr == OFF_INT_MASK)
                || (s_axi_araddr == OFF_EVENT) || (s_axi_araddr == OFF_STATUS)
                || (s_axi_araddr == OFF_INT_STAT) || (s_axi_araddr == OFF_PM_CAP);
  wire rd_istat  = rd_fire && (s_axi_araddr == OFF_INT_STAT);
  wire [31:0] status_word = {24'h0000_00, 1'b0, isolated, main_power_ok,
                             aux_sync, board_wake_out, !power_event_request_n_oe,
                             pme_pending, int_rst};
  wire [31:0] rd_word =
      (s_axi_araddr == OFF_CTRL)     ? {27'h000_0000, ctrl}     :
      (s_axi_araddr == OFF_STATUS)   ? status_word              :
      (s_axi_araddr == OFF_INT_STAT) ? {29'h0000_0000, int_stat} :
      (s_axi_araddr == OFF_INT_MASK) ? {29'h0000_0000, int_mask} :
      (s_axi_araddr == OFF_PM_CAP)   ? {16'h0000, pm_cap}       :
                                       32'h0000_0000;

  // power management event pending until cleared by software
  wire pme_event = ctrl[CTRL_PME_ENABLE] && (ev_packet || ev_link || ev_force);
  wire next_pme  = pme_event || (pme_pending && !ev_clear);

  // wake output styling
  wire wake_cond  = ctrl[CTRL_WAKE_GATE] ? (pme_pending && isolated) // [R5]
                                         : pme_pending;              // [R4]
  wire pulse_on;
  wire wake_idle  = ctrl[CTRL_WAKE_ACTIVE]; // [R3]
  wire wake_level = ctrl[CTRL_WAKE_PULSE] ? pulse_on : wake_cond; // [R3]
  wire wake_pin   = ctrl[CTRL_CARDBUS] ? pme_pending // [R6] [R7]
                                       : (wake_level ^ wake_idle); // [R3]
  logic wake_cond_q;
  wire  pulse_start = wake_cond && !wake_cond_q;

  wsi_pulse u_pulse (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (pulse_start), // [R12]
    .active  (pulse_on)
  );

  // register file and event flags
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl        <= CTRL_RESET;
      int_mask    <= '0;
      int_stat    <= '0;
      pme_pending <= 1'b0;
      pm_cap      <= PM_CAP_NOAUX;
      wake_cond_q <= 1'b0;
    end else if (soft_rst) begin
      ctrl        <= CTRL_RESET;
      int_mask    <= '0;
      int_stat    <= '0;
      pme_pending <= 1'b0;
      pm_cap      <= aux_sync ? PM_CAP_AUX : PM_CAP_NOAUX; // [R10]
      wake_cond_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= w_data[CTRL_WIDTH-1:0];
      end
      if (wr_mask) begin
        int_mask <= w_data[IRQ_WIDTH-1:0];
      end
      pm_cap      <= aux_sync ? PM_CAP_AUX : PM_CAP_NOAUX; // [R10]
      pme_pending <= next_pme;
      wake_cond_q <= wake_cond;
      // set wins over read clear
      int_stat <= (rd_istat ? '0 : int_stat)
                | {pme_event, ev_link, ev_packet};
    end
  end

  // pins, all straight from flip-flops
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      power_event_request_n_out <= 1'b0;
      power_event_request_n_oe  <= 1'b1;
      board_wake_out            <= 1'b0;
      bus_out_enable_n          <= 1'b1;
      bus_in_accept             <= 1'b0;
      irq                       <= 1'b0;
    end else begin
      power_event_request_n_out <= 1'b0; // [R1]
      power_event_request_n_oe  <= !pme_pending; // [R1]
      board_wake_out            <= wake_pin;
      bus_out_enable_n          <= isolated || int_rst; // [R2]
      bus_in_accept             <= !isolated && !int_rst; // [R2]
      irq                       <= |(int_stat & int_mask);
    end
  end

  // axi write channel: address and data taken in either order
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi read channel
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : wsi_top

// File: core/wsi_pkg.sv
/*
  wsi_pkg: constants for the wake signalling and bus isolation block.
  assumes a single 25 MHz clock and AXI4-Lite register access.
*/
package wsi_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_INT_STAT = 8'h08;
  localparam logic [7:0] OFF_INT_MASK = 8'h0C;
  localparam logic [7:0] OFF_EVENT    = 8'h10;
  localparam logic [7:0] OFF_PM_CAP   = 8'h14;
  // control register fields
  localparam int CTRL_WAKE_ACTIVE = 0;  // wake_active_level: 1 low style
  localparam int CTRL_WAKE_PULSE  = 1;  // wake_pulse_select: 1 pulse style
  localparam int CTRL_WAKE_GATE   = 2;  // wake_event_gate
  localparam int CTRL_CARDBUS     = 3;  // cardbus_mode_enable
  localparam int CTRL_PME_ENABLE  = 4;
  localparam int CTRL_WIDTH       = 5;
  localparam logic [4:0] CTRL_RESET = 5'h10;
  // event register fields (write 1 to raise / clear pending event)
  localparam int EV_FORCE = 0;
  localparam int EV_CLEAR = 1;
  // interrupt status bits
  localparam int IRQ_WAKE_PKT = 0;
  localparam int IRQ_LINK_CHG = 1;
  localparam int IRQ_PME      = 2;
  localparam int IRQ_WIDTH    = 3;
  // pm capability: bits 15, 14 and 11 set while aux power is present
  localparam logic [15:0] PM_CAP_AUX = 16'hC800;
  localparam logic [15:0] PM_CAP_NOAUX = 16'h0000;
  // wake pulse length
  localparam int PULSE_NS     = 1000;
  localparam int CLK_NS       = 40;
  localparam int PULSE_CYCLES = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W        = 8;
  // auxiliary power-on reset stretch
  localparam int AUX_RST_CYCLES = 16;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : wsi_pkg

// File: core/wsi_sync.sv
/*
  wsi_sync: two-flop level synchroniser with constant reset value.
  assumes the input may be asynchronous to clk.
*/
`timescale 1ns/1ps
module wsi_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // level in and out
  input  wire logic din,
  output logic      dout
);
  logic stage1;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule : wsi_sync

// File: core/wsi_pulse.sv
/*
  wsi_pulse: fixed-length pulse generator started by a one-cycle trigger.
  assumes trigger is synchronous; retriggers while busy are ignored.
*/
`timescale 1ns/1ps
module wsi_pulse
  import wsi_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // control
  input  wire logic start,
  output logic      active
);
  logic [CNT_W-1:0] count;
  wire              done = (count == CNT_W'(1));
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count  <= '0;
      active <= 1'b0;
    end else if (start && !active) begin
      count  <= CNT_W'(PULSE_CYCLES);
      active <= 1'b1;
    end else if (active) begin
      count  <= count - CNT_W'(1);
      active <= !done;
    end
  end
endmodule : wsi_pulse

// File: test/wsi_properties.sv
/* wsi_properties: port-level checks of the wake and isolation pins.
   assumes the master offers write address and data in the same cycle. */
`timescale 1ns/1ps
module wsi_properties
  import wsi_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // register writes
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  // power, isolation and pins
  input wire logic        aux_power_ok,
  input wire logic        wake_packet_seen,
  input wire logic        bus_isolate_n,
  input wire logic        bus_rst_n,
  input wire logic        bus_out_enable_n,
  input wire logic        bus_in_accept,
  input wire logic        power_event_request_n_out,
  input wire logic        power_event_request_n_oe,
  input wire logic        board_wake_out
);
  logic [7:0] aq;
  logic [7:0] pc;
  logic [4:0] sh;
  logic [4:0] sd1;
  logic [4:0] sd2;
  logic       known;
  wire  [7:0] wa  = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aq;
  wire        oe  = power_event_request_n_oe;
  wire        wk  = board_wake_out;
  wire        al  = sh[CTRL_WAKE_ACTIVE];
  wire        cb  = known && sh[CTRL_CARDBUS];
  wire        lvl = known && !sh[CTRL_CARDBUS] && !sh[CTRL_WAKE_PULSE];
  // the pin shows a new control value two cycles after the shadow takes it
  wire        pls = known && sd2[CTRL_WAKE_PULSE] && !sd2[CTRL_CARDBUS];
  // shadow control value; a hidden internal reset makes it untrusted
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aq <= 8'h00;
      sh <= CTRL_RESET;
      sd1 <= CTRL_RESET;
      sd2 <= CTRL_RESET;
      known <= 1'b1;
      pc <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aq <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready && wa == OFF_CTRL) begin
        sh <= s_axi_wdata[4:0];
        known <= 1'b1;
      end else if ($changed(aux_power_ok) || (!bus_rst_n && bus_isolate_n)) known <= 1'b0;
      sd1 <= sh;
      sd2 <= sd1;
      // count the active cycles of the pin, whatever the request does meanwhile
      pc <= (pls && wk != sd2[CTRL_WAKE_ACTIVE]) ? pc + 8'h01 : 8'h00;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_od; power_event_request_n_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("request pin drives high");
  property p_iso; !bus_isolate_n [*2] |-> bus_out_enable_n && !bus_in_accept; endproperty
  a_iso: assert property (p_iso) else $error("bus not isolated");
  property p_aux; $rose(aux_power_ok) |-> ##[1:8] bus_out_enable_n; endproperty
  a_aux: assert property (p_aux) else $error("no reset on aux power");
  property p_lvl; (lvl && !sh[CTRL_WAKE_GATE] && !oe)[*6] |-> wk != al; endproperty
  a_lvl: assert property (p_lvl) else $error("wake not with request");
  property p_gate; (lvl && sh[CTRL_WAKE_GATE] && bus_isolate_n)[*6] |-> wk == al; endproperty
  a_gate: assert property (p_gate) else $error("gated wake asserted");
  property p_cb_on; (cb && !oe)[*6] |-> wk; endproperty
  a_cb_on: assert property (p_cb_on) else $error("status change low");
  property p_cb_off; (cb && oe)[*6] |-> !wk; endproperty
  a_cb_off: assert property (p_cb_off) else $error("status change high idle");
  property p_pulse; pc != 8'h00 ##1 pc == 8'h00 |-> $past(pc) == PULSE_CYCLES; endproperty
  a_pulse: assert property (p_pulse) else $error("wake pulse length");
  property p_arm;
    known && sh[CTRL_PME_ENABLE] && aux_power_ok && wake_packet_seen && oe && !bus_out_enable_n
      |-> ##[1:3] !oe;
  endproperty
  a_arm: assert property (p_arm) else $error("wake packet ignored");
endmodule : wsi_properties
bind wsi_top wsi_properties i_props (.*);

// File: test/wsi_host_model.sv
/* wsi_host_model: board power logic facing the device pins.
   assumes the bench requests isolation on iso_req. */
`timescale 1ns/1ps
module wsi_host_model (
  // clock and request
  input  wire logic clk,
  input  wire logic iso_req,
  // device pins
  input  wire logic pme_n_out,
  input  wire logic pme_n_oe,
  input  wire logic board_wake_out,
  // board view
  output logic      bus_isolate_n,
  output logic      pme_n_wire,
  output logic      wake_seen
);
  always @(posedge clk) bus_isolate_n <= !iso_req;
  // board pull-up holds the released line high
  assign pme_n_wire = pme_n_oe ? 1'b1 : pme_n_out;
  // level seen here starts the board wake sequence
  always @(posedge clk) wake_seen <= board_wake_out;
endmodule : wsi_host_model

// File: test/wake_signal_isolation_logic_tb_top.sv
/* wake_signal_isolation_logic_tb_top: self-checking bench for wsi_top.
   assumes the host model drives isolation and resolves the request pin. */
`timescale 1ns/1ps
module wake_signal_isolation_logic_tb_top;
  import wsi_pkg::*;
  logic clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
    s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, aux_power_ok,
    main_power_ok, wake_packet_seen, link_change_seen, bus_isolate_n, bus_rst_n,
    bus_out_enable_n, bus_in_accept, power_event_request_n_out, power_event_request_n_oe,
    board_wake_out, irq, iso_req, pme_n_wire, wake_seen;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          failures = 0;
  int          check_count = 0;
  // control value, then isolate_n, idle pin, pin after event, pin 30 cycles on
  logic [11:0] rows [8] = '{12'h10B, 12'h11C, 12'h12A, 12'h13D,
                            12'h148, 12'h143, 12'h1FB, 12'h18B};
  wsi_top i_dut (.*);
  wsi_host_model i_host (.clk(clk), .iso_req(iso_req), .pme_n_out(power_event_request_n_out),
    .pme_n_oe(power_event_request_n_oe), .board_wake_out(board_wake_out),
    .bus_isolate_n(bus_isolate_n), .pme_n_wire(pme_n_wire), .wake_seen(wake_seen));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // address and data are each released at the edge where their own ready is seen high, bready once bvalid is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_open;
    logic w_open;
    logic b_open;
    aw_open = 1'b1;
    w_open  = 1'b1;
    b_open  = 1'b1;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (b_open) begin
      @(posedge clk);
      if (aw_open && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw_open = 1'b0;
      end
      if (w_open && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w_open = 1'b0;
      end
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        b_open = 1'b0;
      end
    end
    chk("bresp", r, RESP_OKAY);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ar_open;
    logic r_open;
    ar_open = 1'b1;
    r_open  = 1'b1;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (r_open) begin
      @(posedge clk);
      if (ar_open && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        ar_open = 1'b0;
      end
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        r_open = 1'b0;
      end
    end
    chk("rdata", d, e);
    chk("rresp", r, er);
  endtask : rd_chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready, s_axi_araddr,
      s_axi_arvalid, s_axi_rready, wake_packet_seen, link_change_seen, iso_req} = '0;
    {sys_rst, aux_power_ok, main_power_ok, bus_rst_n, s_axi_wstrb} = 8'hFF;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (20) @(posedge clk);
    foreach (rows[i]) begin
      wr(OFF_CTRL, {24'h0000_00, rows[i][11:4]});
      iso_req <= !rows[i][3];
      repeat (6) @(negedge clk);
      chk("wake idle", board_wake_out, rows[i][2]);
      chk("bus enable", bus_out_enable_n, !rows[i][3]);
      wr(OFF_EVENT, 32'h0000_0001);
      repeat (4) @(negedge clk);
      chk("wake on", board_wake_out, rows[i][1]);
      chk("host wake", wake_seen, rows[i][1]);
      chk("request", pme_n_wire, 1'b0);
      repeat (30) @(negedge clk);
      chk("wake later", board_wake_out, rows[i][0]);
      wr(OFF_EVENT, 32'h0000_0002);
      repeat (6) @(negedge clk);
      chk("wake off", board_wake_out, rows[i][2]);
      chk("released", pme_n_wire, 1'b1);
    end
    @(posedge clk);
    iso_req <= 1'b0;
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (20) @(posedge clk);
    rd_chk(OFF_CTRL, {27'h0, CTRL_RESET}, RESP_OKAY);
    rd_chk(OFF_PM_CAP, {16'h0000, PM_CAP_AUX}, RESP_OKAY);
    rd_chk(8'h40, 32'h0000_0000, RESP_SLVERR);
    main_power_ok <= 1'b0;
    wr(OFF_INT_MASK, 32'h0000_0002);
    wake_packet_seen <= 1'b1;
    @(posedge clk) wake_packet_seen <= 1'b0;
    repeat (3) @(negedge clk);
    chk("armed", pme_n_wire, 1'b0);
    chk("irq masked", irq, 1'b0);
    @(posedge clk) link_change_seen <= 1'b1;
    @(posedge clk) link_change_seen <= 1'b0;
    repeat (3) @(negedge clk);
    chk("irq", irq, 1'b1);
    rd_chk(OFF_INT_STAT, 32'h0000_0007, RESP_OKAY);
    repeat (2) @(negedge clk);
    chk("irq cleared", irq, 1'b0);
    wr(OFF_EVENT, 32'h0000_0002);
    main_power_ok <= 1'b1;
    wr(OFF_CTRL, 32'h0000_0011);
    aux_power_ok <= 1'b0;
    repeat (6) @(posedge clk);
    rd_chk(OFF_PM_CAP, {16'h0000, PM_CAP_NOAUX}, RESP_OKAY);
    aux_power_ok <= 1'b1;
    repeat (25) @(posedge clk);
    rd_chk(OFF_CTRL, 32'h0000_0010, RESP_OKAY);
    wr(OFF_CTRL, 32'h0000_0011);
    iso_req <= 1'b1;
    repeat (3) @(posedge clk);
    bus_rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    bus_rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    iso_req <= 1'b0;
    repeat (25) @(posedge clk);
    rd_chk(OFF_CTRL, 32'h0000_0011, RESP_OKAY);
    bus_rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    bus_rst_n <= 1'b1;
    repeat (25) @(posedge clk);
    rd_chk(OFF_CTRL, 32'h0000_0010, RESP_OKAY);
    tally_and_finish();
  end
endmodule : wake_signal_isolation_logic_tb_top
